/* File: logic/rsfc_pkg.sv */
// Package for the reset source and flag controller.
// Assumes a single 25 MHz core clock and no software-visible register bus.
package rsfc_pkg;
  // Value that, written to the second flash control register, asks for a full reset.
  localparam logic [7:0] RSFC_SELF_PROG_KEY = 8'h55;
  localparam logic [7:0] RSFC_PORT_RESET = 8'hff;
  localparam logic [7:0] RSFC_PCL_RESET = 8'h00;
  localparam logic [3:0] RSFC_SP_RESET = 4'h0;
  localparam logic [3:0] RSFC_SP_TOP = 4'h0;
  localparam logic RSFC_FLAG_RESET = 1'b0;
  localparam logic [7:0] RSFC_FC1_RESET = 8'h00;
  // Power modes of the core as seen by the reset logic.
  typedef enum logic [1:0] {
    RSFC_MODE_NORMAL,
    RSFC_MODE_SLOW,
    RSFC_MODE_IDLE,
    RSFC_MODE_SLEEP
  } rsfc_mode_t;
  // Kind of reset being applied this cycle.
  typedef enum logic [2:0] {
    RSFC_RST_NONE,
    RSFC_RST_FULL,
    RSFC_RST_WDT_RUN,
    RSFC_RST_WDT_LP,
    RSFC_RST_SUPPLY
  } rsfc_kind_t;
  // Core state that the reset returns to defined conditions.
  typedef struct packed {
    logic [7:0] pc_low;
    logic [3:0] stack_ptr;
    logic int_enable;
    logic wdt_clear;
    logic tb_clear;
    logic timers_on;
    logic [7:0] port_data;
    logic [7:0] port_dir;
  } rsfc_core_t;
  typedef struct packed {
    logic watchdog_timeout_flag;
    logic powerdown_flag;
  } rsfc_flags_t;
endpackage : rsfc_pkg

/* File: logic/rsfc_top.sv */
// Reset source and flag controller: decodes reset requests and applies reset values.
// Assumes requests and core state inputs are synchronous to core_clk_in.
// Summary of operation
// [RULE_01] Writing 55h to the second flash control register causes a full reset.
// [RULE_02] Running watchdog timeout resets like supply drop and sets timeout flag.
// [RULE_03] Low-power watchdog timeout clears only PC and stack pointer, sets timeout flag.
// [RULE_04] Timeout and power-down flags are kept; power-on clears both.
// [RULE_05] Supply-drop reset in normal or slow mode leaves both flags unchanged.
// [RULE_06] Running watchdog reset sets timeout flag, keeps power-down flag.
// [RULE_07] Low-power watchdog reset sets timeout and power-down flags.
// [RULE_08] After power-on all interrupts are disabled until software enables them.
// [RULE_09] After power-on watchdog and time base are cleared; watchdog restarts.
// [RULE_10] After power-on all timer modules are switched off.
// [RULE_11] Power-on and running watchdog resets set port data and direction to ones.
// [RULE_12] After power-on the stack pointer indicates the top of stack.
// [RULE_13] Program counter low byte reads zero after every reset kind.
`timescale 1ns/100ps
`default_nettype none
module rsfc_top (
  input wire logic core_clk_in, // 25 MHz core clock
  input wire logic rst_b_in, // Power-on reset, active low
  input wire logic fc1_wr_in, // Write strobe to second flash control register
  input wire logic [7:0] fc1_wdata_in, // Data written to that register
  input wire logic wdt_timeout_in, // Watchdog timeout pulse
  input wire logic supply_drop_in, // Supply-drop reset request pulse
  input wire logic [1:0] mode_in, // Current power mode (rsfc_mode_t)
  input wire logic int_en_set_in, // Software enables interrupts
  input wire logic timers_on_in, // Software switches timers on
  input wire logic [7:0] port_data_wr_in, // Port data write value
  input wire logic port_data_we_in, // Port data write strobe
  input wire logic [7:0] port_dir_wr_in, // Port direction write value
  input wire logic port_dir_we_in, // Port direction write strobe
  input wire logic [7:0] pc_low_in, // Running program counter low byte
  input wire logic [3:0] sp_in, // Running stack pointer
  input wire logic sleep_enter_in, // Core executes sleep: sets power-down flag
  input wire logic clrwdt_in, // Core clears watchdog: clears both flags
  output logic core_reset_out, // One-cycle reset pulse to the core
  output logic [2:0] reset_kind_out, // Kind of last reset applied (rsfc_kind_t)
  output logic [7:0] pc_low_out, // Program counter low byte
  output logic [3:0] sp_out, // Stack pointer
  output logic int_enable_out, // Global interrupt enable
  output logic wdt_clear_out, // Watchdog counter clear pulse
  output logic tb_clear_out, // Time base counter clear pulse
  output logic timers_on_out, // Timer modules enabled
  output logic [7:0] port_data_out, // Port data register
  output logic [7:0] port_dir_out, // Port direction register, 1 is input
  output logic watchdog_timeout_flag_out, // Status timeout flag
  output logic powerdown_flag_out // Status power-down flag
);

  rsfc_pkg::rsfc_core_t core_reg, core_next;
  rsfc_pkg::rsfc_flags_t flags_reg, flags_next;
  rsfc_pkg::rsfc_kind_t kind_reg, kind_next;
  logic pulse_reg, pulse_next;
  logic low_power;
  rsfc_pkg::rsfc_kind_t req_kind;

  assign low_power = (mode_in == 2'(rsfc_pkg::RSFC_MODE_IDLE)) ||
                     (mode_in == 2'(rsfc_pkg::RSFC_MODE_SLEEP));

  // Priority when several requests coincide: self-program, supply drop, watchdog.
  always_comb begin
    req_kind = rsfc_pkg::RSFC_RST_NONE;
    // [RULE_01] Key write decode.
    if (fc1_wr_in && fc1_wdata_in == rsfc_pkg::RSFC_SELF_PROG_KEY) begin
      req_kind = rsfc_pkg::RSFC_RST_FULL;
    end else if (supply_drop_in && !low_power) begin
      req_kind = rsfc_pkg::RSFC_RST_SUPPLY;
    end else if (wdt_timeout_in) begin
      req_kind = low_power ? rsfc_pkg::RSFC_RST_WDT_LP : rsfc_pkg::RSFC_RST_WDT_RUN;
    end
  end

  always_comb begin
    core_next = core_reg;
    flags_next = flags_reg;
    kind_next = kind_reg;
    pulse_next = 1'b0;
    core_next.pc_low = pc_low_in;
    core_next.stack_ptr = sp_in;
    core_next.wdt_clear = 1'b0;
    core_next.tb_clear = 1'b0;
    if (int_en_set_in) begin
      core_next.int_enable = 1'b1;
    end
    core_next.timers_on = timers_on_in;
    if (port_data_we_in) begin
      core_next.port_data = port_data_wr_in;
    end
    if (port_dir_we_in) begin
      core_next.port_dir = port_dir_wr_in;
    end
    if (clrwdt_in) begin
      flags_next = '0;
    end
    // Entering sleep wins over a clear in the same cycle; a reset request in that cycle overrides both.
    if (sleep_enter_in) begin
      flags_next.powerdown_flag = 1'b1;
    end
    case (req_kind)
      rsfc_pkg::RSFC_RST_NONE: begin
      end
      rsfc_pkg::RSFC_RST_WDT_LP: begin
        // [RULE_03] Only PC and stack pointer cleared.
        core_next.pc_low = rsfc_pkg::RSFC_PCL_RESET;
        core_next.stack_ptr = rsfc_pkg::RSFC_SP_RESET;
        // [RULE_07] Both flags set.
        flags_next.watchdog_timeout_flag = 1'b1;
        flags_next.powerdown_flag = 1'b1;
        // [RULE_11] Ports keep their values even if software writes them now.
        core_next.port_data = core_reg.port_data;
        core_next.port_dir = core_reg.port_dir;
        kind_next = req_kind;
        pulse_next = 1'b1;
      end
      default: begin
        // [RULE_02] Running watchdog and supply drop share register effects.
        core_next.pc_low = rsfc_pkg::RSFC_PCL_RESET;
        // [RULE_12] Stack pointer to top of stack.
        core_next.stack_ptr = rsfc_pkg::RSFC_SP_TOP;
        core_next.int_enable = 1'b0;
        core_next.wdt_clear = 1'b1;
        core_next.tb_clear = 1'b1;
        core_next.timers_on = 1'b0;
        // [RULE_11] Ports become inputs.
        core_next.port_data = rsfc_pkg::RSFC_PORT_RESET;
        core_next.port_dir = rsfc_pkg::RSFC_PORT_RESET;
        // [RULE_06] Timeout flag set, power-down kept.
        if (req_kind == rsfc_pkg::RSFC_RST_WDT_RUN) begin
          flags_next.watchdog_timeout_flag = 1'b1;
          flags_next.powerdown_flag = flags_reg.powerdown_flag;
        end
        // [RULE_05] Supply drop keeps both flags; a full reset clears them like power-on.
        if (req_kind == rsfc_pkg::RSFC_RST_SUPPLY) begin
          flags_next = flags_reg;
        end
        if (req_kind == rsfc_pkg::RSFC_RST_FULL) begin
          flags_next = '0;
        end
        kind_next = req_kind;
        pulse_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // [RULE_08] Interrupts disabled, [RULE_10] timers off, [RULE_13] PC low zero.
      core_reg <= '{pc_low: rsfc_pkg::RSFC_PCL_RESET, stack_ptr: rsfc_pkg::RSFC_SP_TOP,
                    int_enable: 1'b0, wdt_clear: 1'b1, tb_clear: 1'b1, timers_on: 1'b0,
                    port_data: rsfc_pkg::RSFC_PORT_RESET,
                    port_dir: rsfc_pkg::RSFC_PORT_RESET};
      // [RULE_04] Power-on clears both flags.
      flags_reg <= '{rsfc_pkg::RSFC_FLAG_RESET, rsfc_pkg::RSFC_FLAG_RESET};
      kind_reg <= rsfc_pkg::RSFC_RST_NONE;
      pulse_reg <= 1'b0;
    end else begin
      core_reg <= core_next;
      flags_reg <= flags_next;
      kind_reg <= kind_next;
      pulse_reg <= pulse_next;
    end
  end

  assign core_reset_out = pulse_reg;
  assign reset_kind_out = kind_reg;
  assign pc_low_out = core_reg.pc_low;
  assign sp_out = core_reg.stack_ptr;
  assign int_enable_out = core_reg.int_enable;
  // [RULE_09] Counters cleared; watchdog restarts once the pulse ends.
  assign wdt_clear_out = core_reg.wdt_clear;
  assign tb_clear_out = core_reg.tb_clear;
  assign timers_on_out = core_reg.timers_on;
  assign port_data_out = core_reg.port_data;
  assign port_dir_out = core_reg.port_dir;
  assign watchdog_timeout_flag_out = flags_reg.watchdog_timeout_flag;
  assign powerdown_flag_out = flags_reg.powerdown_flag;

  // Request shapes shared by the checks below; every check except chk_pcl_zero looks one cycle after its antecedent.
  sequence s_key_write;
    fc1_wr_in && fc1_wdata_in == rsfc_pkg::RSFC_SELF_PROG_KEY;
  endsequence
  sequence s_full_reset;
    core_reset_out && pc_low_out == 8'h00 && port_dir_out == 8'hff && !int_enable_out;
  endsequence
  sequence s_running_reset;
    req_kind == rsfc_pkg::RSFC_RST_FULL || req_kind == rsfc_pkg::RSFC_RST_WDT_RUN ||
    req_kind == rsfc_pkg::RSFC_RST_SUPPLY;
  endsequence
  sequence s_lp_timeout;
    req_kind == rsfc_pkg::RSFC_RST_WDT_LP;
  endsequence
  sequence s_no_flag_event;
    req_kind == rsfc_pkg::RSFC_RST_NONE && !sleep_enter_in && !clrwdt_in;
  endsequence

  // [RULE_01] Key write resets.
  chk_key_full_reset: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_01]
    s_key_write |=> s_full_reset) else $error("key write did not reset");

  // [RULE_01] Key reset clears flags.
  chk_key_flags: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_01]
    s_key_write
    |=> !watchdog_timeout_flag_out && !powerdown_flag_out) else $error("key reset kept flags");

  // [RULE_06] Running timeout flags.
  chk_wdt_run_flag: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_06]
    (req_kind == rsfc_pkg::RSFC_RST_WDT_RUN) |=> watchdog_timeout_flag_out
    && powerdown_flag_out == $past(powerdown_flag_out)) else $error("run timeout flags wrong");

  // [RULE_02] Running timeout effects.
  chk_wdt_run_ports: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_02]
    (req_kind == rsfc_pkg::RSFC_RST_WDT_RUN) |=> port_data_out == 8'hff && !timers_on_out
    && wdt_clear_out) else $error("run timeout effects wrong");

  // [RULE_02] Supply drop effects.
  chk_supply_ports: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_02]
    (req_kind == rsfc_pkg::RSFC_RST_SUPPLY) |=> port_data_out == 8'hff && port_dir_out == 8'hff
    && !timers_on_out && tb_clear_out) else $error("supply drop effects wrong");

  // [RULE_12] Stack to top.
  chk_run_stack: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_12]
    (req_kind == rsfc_pkg::RSFC_RST_WDT_RUN)
    |=> sp_out == rsfc_pkg::RSFC_SP_TOP) else $error("stack pointer not at top");

  // [RULE_03] Low-power timeout keeps state.
  chk_wdt_lp_keep: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_03]
    (req_kind == rsfc_pkg::RSFC_RST_WDT_LP) |=> sp_out == 4'h0
    && port_dir_out == $past(port_dir_out)) else $error("low-power timeout changed state");

  // [RULE_03] No counter clears.
  chk_lp_no_clear: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_03]
    s_lp_timeout
    |=> !wdt_clear_out && !tb_clear_out) else $error("low-power timeout cleared counters");

  // [RULE_11] Ports kept in low power.
  chk_lp_ports: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_11]
    s_lp_timeout |=> port_data_out == $past(port_data_out)
    && port_dir_out == $past(port_dir_out)) else $error("low-power timeout changed ports");

  // [RULE_07] Low-power timeout flags.
  chk_wdt_lp_flags: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_07]
    (req_kind == rsfc_pkg::RSFC_RST_WDT_LP) |=> watchdog_timeout_flag_out
    && powerdown_flag_out) else $error("low-power timeout flags wrong");

  // [RULE_13] Low-power timeout pulse.
  chk_lp_kind: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_13]
    s_lp_timeout |=> core_reset_out && pc_low_out == 8'h00
    && reset_kind_out == 3'(rsfc_pkg::RSFC_RST_WDT_LP)) else $error("low-power timeout kind wrong");

  // [RULE_05] Supply drop keeps flags.
  chk_supply_flags: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_05]
    (req_kind == rsfc_pkg::RSFC_RST_SUPPLY) |=> $stable(watchdog_timeout_flag_out)
    && $stable(powerdown_flag_out)) else $error("supply drop changed flags");

  // [RULE_05] Supply drop refused asleep.
  chk_supply_refused: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_05]
    supply_drop_in && low_power && !wdt_timeout_in && !fc1_wr_in
    |=> !core_reset_out) else $error("supply drop taken in low power");

  // [RULE_04] Flags held when idle.
  chk_flags_hold: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_04]
    s_no_flag_event |=> $stable(watchdog_timeout_flag_out)
    && $stable(powerdown_flag_out)) else $error("flags changed without cause");

  // [RULE_04] Sleep sets power-down.
  chk_sleep_pdf: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_04]
    sleep_enter_in && req_kind == rsfc_pkg::RSFC_RST_NONE
    |=> powerdown_flag_out) else $error("sleep did not set power-down flag");

  // [RULE_13] PC low zero.
  chk_pcl_zero: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_13]
    core_reset_out |-> pc_low_out == 8'h00) else $error("pc low not zero after reset");

  // [RULE_08] Interrupts held off.
  chk_int_off: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_08]
    (core_reset_out && reset_kind_out != 3'(rsfc_pkg::RSFC_RST_WDT_LP) && !int_en_set_in)
    |=> !int_enable_out) else $error("interrupts not held off");

  // [RULE_08] Interrupts off on reset.
  chk_run_int_off: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_08]
    s_running_reset
    |=> !int_enable_out) else $error("interrupts enabled after reset");

  // [RULE_10] Timers switched off.
  chk_timers_off: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_10]
    s_running_reset
    |=> !timers_on_out) else $error("timers left on after reset");

  // [RULE_09] Counters cleared.
  chk_run_clears: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_09]
    s_running_reset
    |=> wdt_clear_out && tb_clear_out) else $error("counters not cleared by reset");

  // [RULE_09] Watchdog restarts.
  chk_wdt_restart: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RULE_09]
    wdt_clear_out && !$past(wdt_clear_out) && req_kind == rsfc_pkg::RSFC_RST_NONE
    |=> !wdt_clear_out) else $error("watchdog clear held");

endmodule : rsfc_top
`default_nettype wire

/* File: tb/test_reset_source_flag_control.sv */
// Self-checking bench for the reset source and flag controller.
// Assumes rsfc_pkg and rsfc_top are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
module test_reset_source_flag_control;
  typedef struct packed {
    logic [1:0] ev; // 0 key write, 1 watchdog, 2 supply drop, 3 wrong key
    logic [1:0] mode;
    logic pd;
    logic rst;
    logic [2:0] kind;
    logic [1:0] flg; // timeout flag, power-down flag
    logic [7:0] port;
    logic inten;
  } rsfc_row_t;
  logic clk = 1'b0, rst_b = 1'b0, fc1_wr = 1'b0, wdt = 1'b0, sup = 1'b0;
  logic sleep = 1'b0, clr = 1'b0, inten_set = 1'b0, we = 1'b0;
  logic [7:0] fc1_d = 8'h00;
  logic [1:0] mode = 2'h0;
  logic rst_o, int_o, wclr_o, tbclr_o, tmr_o, to_o, pdf_o;
  logic [2:0] kind_o;
  logic [7:0] pc_o, pd_o, pdir_o;
  logic [3:0] sp_o;
  int fails = 0, tests_run = 0, cyc = 0, i;
  // Rows cover the watchdog in every mode, the key write in normal mode, supply drop in normal, slow and sleep, plus refused requests.
  rsfc_row_t rows [9] = '{
    '{2'h0, 2'h0, 1'b1, 1'b1, 3'h1, 2'b00, 8'hff, 1'b0},
    '{2'h1, 2'h0, 1'b0, 1'b1, 3'h2, 2'b10, 8'hff, 1'b0},
    '{2'h1, 2'h1, 1'b1, 1'b1, 3'h2, 2'b11, 8'hff, 1'b0},
    '{2'h1, 2'h2, 1'b0, 1'b1, 3'h3, 2'b11, 8'h0f, 1'b1},
    '{2'h1, 2'h3, 1'b0, 1'b1, 3'h3, 2'b11, 8'h0f, 1'b1},
    '{2'h2, 2'h0, 1'b1, 1'b1, 3'h4, 2'b01, 8'hff, 1'b0},
    '{2'h2, 2'h1, 1'b0, 1'b1, 3'h4, 2'b00, 8'hff, 1'b0},
    '{2'h2, 2'h3, 1'b1, 1'b0, 3'h0, 2'b01, 8'h0f, 1'b1},
    '{2'h3, 2'h0, 1'b0, 1'b0, 3'h0, 2'b00, 8'h0f, 1'b1}};

  rsfc_top rsfc_top_i (.core_clk_in(clk), .rst_b_in(rst_b), .fc1_wr_in(fc1_wr),
    .fc1_wdata_in(fc1_d), .wdt_timeout_in(wdt), .supply_drop_in(sup), .mode_in(mode),
    .int_en_set_in(inten_set), .timers_on_in(1'b1), .port_data_wr_in(8'h0f),
    .port_data_we_in(we), .port_dir_wr_in(8'h0f), .port_dir_we_in(we),
    .pc_low_in(8'h3c), .sp_in(4'h5), .sleep_enter_in(sleep), .clrwdt_in(clr),
    .core_reset_out(rst_o), .reset_kind_out(kind_o), .pc_low_out(pc_o), .sp_out(sp_o),
    .int_enable_out(int_o), .wdt_clear_out(wclr_o), .tb_clear_out(tbclr_o),
    .timers_on_out(tmr_o), .port_data_out(pd_o), .port_dir_out(pdir_o),
    .watchdog_timeout_flag_out(to_o), .powerdown_flag_out(pdf_o));

  always #20 clk = ~clk;

  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Clears both flags, loads ports with 0f, enables interrupts, then optionally sleeps.
  task prep(input logic p);
    @(posedge clk);
    mode <= 2'h0;
    clr <= 1'b1;
    we <= 1'b1;
    inten_set <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    we <= 1'b0;
    inten_set <= 1'b0;
    sleep <= p;
    @(posedge clk);
    sleep <= 1'b0;
  endtask : prep

  // One request for one cycle; returns at the falling edge of the answer cycle.
  task fire(input logic [1:0] ev, input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    fc1_wr <= (ev == 2'h0) || (ev == 2'h3);
    fc1_d <= (ev == 2'h0) ? rsfc_pkg::RSFC_SELF_PROG_KEY : 8'haa;
    wdt <= (ev == 2'h1);
    sup <= (ev == 2'h2);
    @(posedge clk);
    fc1_wr <= 1'b0;
    wdt <= 1'b0;
    sup <= 1'b0;
    @(negedge clk);
  endtask : fire

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      $display("MISMATCH t=%0t run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    chk({2'b0, int_o, wclr_o, tbclr_o, tmr_o, to_o, pdf_o}, 8'h18, "por state");
    chk({pc_o[3:0], sp_o}, {4'h0, rsfc_pkg::RSFC_SP_TOP}, "por pc sp");
    chk(pd_o & pdir_o, 8'hff, "por ports");
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge clk);
    chk({6'h0, wclr_o, tbclr_o}, 8'h00, "watchdog restart");
    for (i = 0; i < 9; i++) begin
      prep(rows[i].pd);
      fire(rows[i].ev, rows[i].mode);
      chk(8'(rst_o), 8'(rows[i].rst), "reset pulse");
      if (rows[i].rst) chk(8'(kind_o), 8'(rows[i].kind), "kind");
      chk(pc_o, rows[i].rst ? 8'h00 : 8'h3c, "pc low");
      chk(8'(sp_o), rows[i].rst ? 8'h00 : 8'h05, "stack ptr");
      chk(8'({to_o, pdf_o}), 8'(rows[i].flg), "flags");
      chk(pd_o, rows[i].port, "port data");
      chk(pdir_o, rows[i].port, "port dir");
      chk(8'(int_o), 8'(rows[i].inten), "int enable");
      chk(8'({wclr_o, tbclr_o, tmr_o}), (rows[i].rst && rows[i].kind != 3'h3) ? 8'h06 : 8'h01, "clears");
    end
    // Watchdog then supply drop, one idle cycle apart: the timeout flag must survive a supply-drop reset.
    prep(1'b0);
    fire(2'h1, 2'h0);
    fire(2'h2, 2'h1);
    chk(8'({rst_o, to_o, pdf_o}), 8'h06, "flags kept");
    // A second power-on reset in mid-run clears the flags at once.
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    chk(8'({to_o, pdf_o, int_o}), 8'h00, "mid reset");
    end_sim();
  end
endmodule : test_reset_source_flag_control
`default_nettype wire
